// ==== inc/glyph_pkg.sv ====
// Shared constants and carrier types for the user glyph lookup block
`default_nettype none
package glyph_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PAT_ADDR_OFS = 4'h4;
  localparam logic [3:0] PAT_DATA_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;

  // Control register fields
  localparam int CTRL_FW_BIT = 0;
  localparam int CTRL_BE_BIT = 1;
  // Status register fields
  localparam int STAT_BLINK_OFF_BIT = 0;
  localparam int STAT_USER_SEL_BIT = 1;

  // Values after reset
  localparam logic CTRL_FW_RESET = 1'h0;
  localparam logic CTRL_BE_RESET = 1'h0;
  localparam logic [5:0] PAT_ADDR_RESET = 6'h00;
  localparam logic [31:0] READDATA_RESET = 32'h0000_0000;

  // Bus answer timing: waitrequest drops when the counter reaches this
  localparam logic [1:0] BUS_ACK_CNT = 2'h2;
  localparam logic [1:0] BUS_READ_CNT = 2'h1;

  // Character code decode
  localparam logic [3:0] USER_CODE_HIGH = 4'h0;
  localparam int CODE_HIGH_LSB = 4;
  localparam logic [2:0] CURSOR_LINE = 3'h7;

  // Dot row bit positions
  localparam int BLINK_ROW_BIT = 7;
  localparam int BLINK_LEFT_BIT = 6;
  localparam int LEFT_DOT_NARROW = 4;
  localparam int LEFT_DOT_WIDE = 5;
  localparam logic [5:0] NARROW_MASK = 6'h1F;
  localparam logic [5:0] WIDE_MASK = 6'h3F;

  // Frames per blink half period
  localparam logic [5:0] BLINK_HALF_FRAMES = 6'h20;

  // Scan request from the row scanner, one per glyph line fetch
  typedef struct packed {
    logic valid;
    logic [7:0] char_code;
    logic [2:0] line_idx;
    logic [5:0] cursor;
  } scan_req_s;

  // Dot row answer to the segment drive logic
  typedef struct packed {
    logic valid;
    logic user_sel;
    logic [5:0] dots;
  } dot_row_s;

endpackage : glyph_pkg
`default_nettype wire

// ==== verilog/glyph_store.sv ====
// 64 x 8 user pattern memory with a scan read port and a bus read port
`timescale 1ns/10ps
`default_nettype none
module glyph_store (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [5:0] scan_addr,
  output logic [7:0] scan_q,
  input wire logic [5:0] bus_addr,
  output logic [7:0] bus_q
);

  typedef struct packed {
    logic [7:0] scan_q;
    logic [7:0] bus_q;
  } store_state_s;

  logic [7:0] mem [0:63];
  store_state_s st;
  store_state_s next_st;

  // Both read ports see the array before this cycle's write
  always_comb begin
    next_st = st;
    next_st.scan_q = mem[scan_addr];
    next_st.bus_q = mem[bus_addr];
  end

  // Array holds no reset; software loads glyphs after power up
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign scan_q = st.scan_q;
  assign bus_q = st.bus_q;

endmodule : glyph_store
`default_nettype wire

// ==== verilog/blink_timer.sv ====
// Blink phase generator counting display frames
`timescale 1ns/10ps
`default_nettype none
module blink_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic frame_tick,
  output logic blink_off
);

  typedef struct packed {
    logic [5:0] frames;
    logic blink_off;
  } blink_state_s;

  blink_state_s st;
  blink_state_s next_st;

  // Phase flips every half period, shared by all glyphs
  always_comb begin
    next_st = st;
    if (frame_tick) begin
      if (st.frames == glyph_pkg::BLINK_HALF_FRAMES - 6'h01) begin
        next_st.frames = 6'h00;
        next_st.blink_off = ~st.blink_off;
      end else begin
        next_st.frames = st.frames + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign blink_off = st.blink_off;

endmodule : blink_timer
`default_nettype wire

// ==== verilog/user_pattern_ram_pattern_lookup.sv ====
// User glyph lookup: text code to pattern row, cursor merge, blink, register slave
//
// Functional notes
// - Upper code nibble zero selects user patterns
// - Code bit 3 ignored for pattern address
// - Code bits 2..0 drive address 5..3
// - Line index drives address bits 2..0
// - Eighth line ORs stored row with cursor
// - Row bit 0 is the rightmost dot
// - Narrow width uses bits 4..0, wide 5..0
// - One bit lights a dot, zero not
// - Top two bits blink control only when enabled
// - Bit 7 blinks every lit dot of row
// - Bit 6 blinks only the leftmost dot
`timescale 1ns/10ps
`default_nettype none
module user_pattern_ram_pattern_lookup (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_tick,
  input wire glyph_pkg::scan_req_s scan_in,
  output glyph_pkg::dot_row_s row_out
);

  // Timing overview, one line per clock edge with ce high
  // Scan c0: request fields on scan_in, memory address formed
  // Scan edge 0: memory row captured, request fields into stage 1
  // Scan c1: width mask, blink blanking and cursor merge worked out
  // Scan edge 1: dot row registered, valid raised for one cycle
  // Scan c2: segment side takes the row; dots hold until next valid
  // Bus c0: read or write raised, waitrequest high
  // Bus edge 0: answer counter to one
  // Bus edge 1: read data captured, counter to two
  // Bus c2: waitrequest low, read data already settled
  // Bus edge 2: write lands, pattern pointer steps
  //
  // Hazards and limits
  // Pointer and bus read port share one address; a pattern
  // readback right after a pointer write fetches the new row at
  // its edge 0, so needs no idle access; the bus task always leaves a gap cycle
  // Pattern writes and scan reads to the same row in one
  // cycle show the old row; the new row shows next fetch
  // Blink phase is global, so all blinking glyphs change
  // together, traded against a per-glyph counter
  // Cursor is merged after blanking so it never blinks away
  // Codes outside the user range give a dark row here; the
  // fixed glyph tables live elsewhere
  // Low ce stretches both pipelines and the bus answer alike
  //
  typedef struct packed {
    logic [1:0] bus_cnt;
    logic [31:0] readdata;
    logic font_width_select;
    logic blink_enable_bit;
    logic [5:0] pat_addr;
    logic s1_valid;
    logic s1_user_sel;
    logic [2:0] s1_line;
    logic [5:0] s1_cursor;
    glyph_pkg::dot_row_s out;
  } lookup_state_s;

  lookup_state_s st;
  lookup_state_s next_st;

  logic bus_req;
  logic bus_ack;
  logic [1:0] reg_sel;
  logic ram_wr_en;
  logic [5:0] scan_addr;
  logic [7:0] scan_q;
  logic [7:0] bus_q;
  logic blink_off;
  logic user_hit;

  // Bus request is held by the master until waitrequest is seen low
  assign bus_req = avs_read | avs_write;
  assign bus_ack = bus_req && (st.bus_cnt == glyph_pkg::BUS_ACK_CNT);
  assign avs_waitrequest = bus_req && !bus_ack;
  assign avs_readdata = st.readdata;
  assign reg_sel = avs_address[3:2];
  // Pattern writes land at the acknowledging edge only
  assign ram_wr_en = bus_ack && avs_write && (reg_sel == glyph_pkg::PAT_DATA_OFS[3:2]);

  assign user_hit = scan_in.char_code[7:glyph_pkg::CODE_HIGH_LSB] == glyph_pkg::USER_CODE_HIGH;

  assign scan_addr = {scan_in.char_code[2:0], scan_in.line_idx};

  glyph_store u_store (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr_en(ram_wr_en),
    .wr_addr(st.pat_addr),
    .wr_data(avs_writedata[7:0]),
    .scan_addr(scan_addr),
    .scan_q(scan_q),
    .bus_addr(st.pat_addr),
    .bus_q(bus_q)
  );

  blink_timer u_blink (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .frame_tick(frame_tick),
    .blink_off(blink_off)
  );

  // Register slave and scan pipeline
  always_comb begin
    logic [5:0] width_mask;
    logic [5:0] stored;
    logic [5:0] cursor;
    logic [5:0] blank;
    next_st = st;
    width_mask = glyph_pkg::NARROW_MASK;
    stored = 6'h00;
    cursor = 6'h00;
    blank = 6'h00;

    // Fixed answer time: count up while a request is held
    if (bus_req && !bus_ack) begin
      next_st.bus_cnt = st.bus_cnt + 2'h1;
    end else begin
      next_st.bus_cnt = 2'h0;
    end

    // Read data is captured at the same edge that drops waitrequest
    if (avs_read && st.bus_cnt == glyph_pkg::BUS_READ_CNT) begin
      next_st.readdata = glyph_pkg::READDATA_RESET;
      case (reg_sel)
        glyph_pkg::CTRL_OFS[3:2]: begin
          next_st.readdata[glyph_pkg::CTRL_FW_BIT] = st.font_width_select;
          next_st.readdata[glyph_pkg::CTRL_BE_BIT] = st.blink_enable_bit;
        end
        glyph_pkg::PAT_ADDR_OFS[3:2]: begin
          next_st.readdata[5:0] = st.pat_addr;
        end
        glyph_pkg::PAT_DATA_OFS[3:2]: begin
          next_st.readdata[7:0] = bus_q;
        end
        glyph_pkg::STATUS_OFS[3:2]: begin
          next_st.readdata[glyph_pkg::STAT_BLINK_OFF_BIT] = blink_off;
          next_st.readdata[glyph_pkg::STAT_USER_SEL_BIT] = st.out.user_sel;
        end
        default: begin
          next_st.readdata = glyph_pkg::READDATA_RESET;
        end
      endcase
    end

    // Writes and the pattern pointer step at the acknowledging edge
    if (bus_ack && avs_write) begin
      case (reg_sel)
        glyph_pkg::CTRL_OFS[3:2]: begin
          next_st.font_width_select = avs_writedata[glyph_pkg::CTRL_FW_BIT];
          next_st.blink_enable_bit = avs_writedata[glyph_pkg::CTRL_BE_BIT];
        end
        glyph_pkg::PAT_ADDR_OFS[3:2]: begin
          next_st.pat_addr = avs_writedata[5:0];
        end
        glyph_pkg::PAT_DATA_OFS[3:2]: begin
          next_st.pat_addr = st.pat_addr + 6'h01;
        end
        default: begin
          next_st.pat_addr = st.pat_addr;
        end
      endcase
    end
    // Streaming readback walks the pattern memory too
    if (bus_ack && avs_read && reg_sel == glyph_pkg::PAT_DATA_OFS[3:2]) begin
      next_st.pat_addr = st.pat_addr + 6'h01;
    end

    // Stage 1: memory read in flight, request fields held
    next_st.s1_valid = scan_in.valid;
    next_st.s1_user_sel = user_hit;
    next_st.s1_line = scan_in.line_idx;
    next_st.s1_cursor = scan_in.cursor;

    if (st.font_width_select) begin
      width_mask = glyph_pkg::WIDE_MASK;
    end
    stored = scan_q[5:0] & width_mask;

    if (st.blink_enable_bit && blink_off) begin
      if (scan_q[glyph_pkg::BLINK_ROW_BIT]) begin
        blank = stored;
      end
      if (scan_q[glyph_pkg::BLINK_LEFT_BIT]) begin
        if (st.font_width_select) begin
          blank[glyph_pkg::LEFT_DOT_WIDE] = 1'b1;
        end else begin
          blank[glyph_pkg::LEFT_DOT_NARROW] = 1'b1;
        end
      end
    end

    if (st.s1_line == glyph_pkg::CURSOR_LINE) begin
      cursor = st.s1_cursor & width_mask;
    end

    // Stage 2: ROM glyphs are not ours, so a non-user code shows blank
    next_st.out.valid = st.s1_valid;
    next_st.out.user_sel = st.s1_valid ? st.s1_user_sel : st.out.user_sel;
    if (st.s1_valid) begin
      if (st.s1_user_sel) begin
        next_st.out.dots = (stored & ~blank) | cursor;
      end else begin
        next_st.out.dots = 6'h00;
      end
    end
  end

  // Single state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.font_width_select <= glyph_pkg::CTRL_FW_RESET;
      st.blink_enable_bit <= glyph_pkg::CTRL_BE_RESET;
      st.pat_addr <= glyph_pkg::PAT_ADDR_RESET;
      st.readdata <= glyph_pkg::READDATA_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign row_out = st.out;

endmodule : user_pattern_ram_pattern_lookup
`default_nettype wire

// ==== bench/glyph_lookup_props.sv ====
// Port-level checks on the glyph lookup block
`timescale 1ns/10ps
`default_nettype none
module glyph_lookup_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic frame_tick,
  input wire glyph_pkg::scan_req_s scan_in,
  input wire glyph_pkg::dot_row_s row_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_user_pick: assert property (
    scan_in.valid && ce && scan_in.char_code[7:4] == 4'h0 ##1 ce [*2] |-> row_out.valid && row_out.user_sel)
    else $error("user row missing");
  chk_other_dark: assert property (
    scan_in.valid && ce && scan_in.char_code[7:4] != 4'h0 ##1 ce [*2]
    |-> row_out.valid && !row_out.user_sel && row_out.dots == 6'h00) else $error("other code row wrong");
  chk_cursor_or: assert property (
    scan_in.valid && ce && scan_in.line_idx == 3'h7 && scan_in.char_code[7:4] == 4'h0 ##1 ce [*2]
    |-> (row_out.dots[4:0] & $past(scan_in.cursor[4:0], 2)) == $past(scan_in.cursor[4:0], 2))
    else $error("cursor dots lost");
  chk_row_cause: assert property (row_out.valid |-> $past(scan_in.valid, 2)) else $error("row without fetch");
  // Row fields hold between answers
  chk_row_hold: assert property (!row_out.valid |-> $stable(row_out.dots) && $stable(row_out.user_sel))
    else $error("row changed while idle");
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
  // Answer on the third edge
  chk_wait_three: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late or early");
  chk_wait_once: assert property ((avs_read || avs_write) && !avs_waitrequest
    |=> avs_waitrequest || !(avs_read || avs_write)) else $error("answer held too long");
  chk_rdata_move: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved");
  cover property (row_out.valid && row_out.user_sel);
  cover property (scan_in.valid && scan_in.line_idx == 3'h7);
  cover property (avs_write && !avs_waitrequest);
endmodule : glyph_lookup_props
bind user_pattern_ram_pattern_lookup glyph_lookup_props i_glyph_lookup_props (.clk(clk), .srst(srst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_tick(frame_tick),
  .scan_in(scan_in), .row_out(row_out));
`default_nettype wire

// ==== bench/row_scan_model.sv ====
// Row scanner stand-in: issues glyph fetches and frame ticks
`timescale 1ns/10ps
`default_nettype none
module row_scan_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick_en,
  input wire glyph_pkg::scan_req_s req,
  output glyph_pkg::scan_req_s scan_in,
  output logic frame_tick
);
  logic [1:0] div;
  // Frame every four cycles; idle fields scrambled so stale values prove nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      div <= 2'h0;
      frame_tick <= 1'b0;
      scan_in <= '0;
    end else begin
      div <= div + 2'h1;
      frame_tick <= tick_en && div == 2'h3;
      scan_in <= req.valid ? req : {1'b0, ~scan_in[16:0]};
    end
  end
endmodule : row_scan_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the glyph lookup block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, srst = 1, ce = 1, avs_read = 0, avs_write = 0, tick_en = 0, frame_tick, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  glyph_pkg::scan_req_s req = '0, scan_in;
  glyph_pkg::dot_row_s row_out;
  logic [7:0] pat [64];
  logic [6:0] q [$];
  logic wide = 0, blk = 0;
  int fail_count = 0, compares = 0, ticks = 0, cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  user_pattern_ram_pattern_lookup i_user_pattern_ram_pattern_lookup (.clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_tick(frame_tick), .scan_in(scan_in), .row_out(row_out));
  row_scan_model i_row_scan_model (.clk(clk), .srst(srst), .tick_en(tick_en), .req(req), .scan_in(scan_in),
    .frame_tick(frame_tick));
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk_reg
  task automatic chk_row(input logic [6:0] e, input logic [6:0] s);
    chk_reg("row", 32'(e), 32'(s));
  endtask : chk_row
  // Master holds the request until waitrequest is seen low, then idles a cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) fail_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Expected user flag and dots, worked out from the stored pattern
  function automatic logic [6:0] expect_row(logic [7:0] c, logic [2:0] l, logic [5:0] cur);
    logic [7:0] r;
    logic [5:0] w, b;
    r = pat[{c[2:0], l}];
    w = wide ? 6'h3F : 6'h1F;
    b = 6'h00;
    if (blk && ticks[5]) begin
      if (r[7]) b = 6'h3F;
      if (r[6]) b[wide ? 5 : 4] = 1'b1;
    end
    if (c[7:4] != 4'h0) return 7'h00;
    return {1'b1, (r[5:0] & w & ~b) | (l == 3'h7 ? cur & w : 6'h00)};
  endfunction : expect_row
  // Back-to-back fetches, every odd one a user code with bit 3 random
  task automatic scan_burst(input int n);
    glyph_pkg::scan_req_s s;
    for (int i = 0; i < n; i++) begin
      s = 18'($urandom);
      s.valid = 1'b1;
      if (i[0]) s.char_code[7:4] = 4'h0;
      q.push_back(expect_row(s.char_code, s.line_idx, s.cursor));
      req <= s;
      @(posedge clk);
    end
    req.valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : scan_burst
  task automatic tick32;
    int t = ticks + 32;
    tick_en <= 1'b1;
    while (ticks < t) @(posedge clk);
    tick_en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tick32
  // Watcher: frame count, row answers in order, hang limit
  always @(posedge clk) begin
    cyc++;
    if (frame_tick === 1'b1) ticks++;
    if (row_out.valid === 1'b1) chk_row(q.pop_front(), {row_out.user_sel, row_out.dots});
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'hccd0ec36));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // Control and pointer come up cleared
    for (int a = 0; a < 2; a++) begin
      bus(1'b0, a ? glyph_pkg::PAT_ADDR_OFS : glyph_pkg::CTRL_OFS, 32'h0000_0000);
      chk_reg("reset", 32'h0000_0000, rd);
    end
    bus(1'b1, glyph_pkg::PAT_ADDR_OFS, 32'h0000_0000);
    for (int i = 0; i < 64; i++) begin
      pat[i] = 8'($urandom);
      bus(1'b1, glyph_pkg::PAT_DATA_OFS, {24'h00_0000, pat[i]});
    end
    // Pointer wrapped, readback then steps it
    bus(1'b0, glyph_pkg::PAT_DATA_OFS, 32'h0000_0000);
    chk_reg("pat0", {24'h00_0000, pat[0]}, rd);
    bus(1'b0, glyph_pkg::PAT_ADDR_OFS, 32'h0000_0000);
    chk_reg("ptr", 32'h0000_0001, rd);
    // Every width and blink setting, in both blink phases
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, glyph_pkg::CTRL_OFS, 32'(m));
      wide = m[0];
      blk = m[1];
      repeat (2) begin
        scan_burst(24);
        tick32;
        bus(1'b0, glyph_pkg::STATUS_OFS, 32'h0000_0000);
        chk_reg("phase", 32'(ticks[5]), rd & 32'h0000_0001);
      end
    end
    chk_reg("left", 32'h0000_0000, 32'(q.size()));
    test_done;
  end
endmodule : tb
`default_nettype wire
